// [caw_checker.sv]
`timescale 1ns/10ps
module caw_checker
  import caw_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic [CAW_AW-1:0] addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              irq_o,
  input wire logic              wdog_reset_o,
  input wire logic              reset_pin_oe_o,
  input wire logic              m4_compare_o
);
  // ==========
  // Shadow of the bits the watchdog depends on
  // ==========
  logic [7:0] mode_reg;
  logic [7:0] m4_reg;
  logic       wmsk_reg;
  logic       cmp_mode;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_reg <= 8'h00;
      m4_reg   <= 8'h00;
      wmsk_reg <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        CAW_ADDR_MODE:    mode_reg <= wdata_i;
        CAW_ADDR_M4_MODE: m4_reg <= wdata_i;
        CAW_ADDR_CMP_LO:  m4_reg[CAW_M4_CMPEN] <= 1'b0;
        CAW_ADDR_CMP_HI:  m4_reg[CAW_M4_CMPEN] <= 1'b1;
        CAW_ADDR_IRQ_MSK: wmsk_reg <= wdata_i[CAW_IRQ_WDOG];
        default:          ;
      endcase
    end
  end

  assign cmp_mode = m4_reg[CAW_M4_CMPEN] & m4_reg[CAW_M4_MATCH]
                  & ~(m4_reg[CAW_M4_PWM] | m4_reg[CAW_M4_CAPP]
                  | m4_reg[CAW_M4_CAPN]);

  // ==========
  // Properties
  // ==========
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence fire_s;
    $rose(wdog_reset_o);
  endsequence
  sequence pulse_s;
    wdog_reset_o [*4] ##1 !wdog_reset_o;
  endsequence

  pin_idle_a: assert property (!reset_pin_oe_o)
    else $error("reset pin enable raised");
  pulse_width_a: assert property (fire_s |-> pulse_s)
    else $error("watchdog reset pulse not four cycles");
  fire_enabled_a: assert property (
    fire_s |-> $past(mode_reg[CAW_MODE_WATCHDOG_ENABLE_BIT]))
    else $error("watchdog reset without enable");
  fire_mode_a: assert property (fire_s |-> $past(cmp_mode))
    else $error("watchdog reset outside compare mode");
  fire_irq_a: assert property (fire_s ##0 wmsk_reg |-> ##[0:2] irq_o)
    else $error("unmasked watchdog event without interrupt");
  toggle_mode_a: assert property (
    $changed(m4_compare_o) |-> $past(m4_reg[CAW_M4_TOG]))
    else $error("compare output moved without toggle mode");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read answer cycle");
  reset_clear_a: assert property ($fell(reset_i) |->
    !wdog_reset_o && !irq_o && rdata_o == 8'h00)
    else $error("outputs not clear after reset");
endmodule

bind caw_top caw_checker chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .wdog_reset_o(wdog_reset_o), .reset_pin_oe_o(reset_pin_oe_o),
  .m4_compare_o(m4_compare_o)
);

// [caw_counter.sv]
`timescale 1ns/10ps
module caw_counter
  import caw_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  caw_ctr_if.counter ctr
);

  logic [15:0] count_reg;
  logic        tick_reg;
  logic        ovf_reg;
  logic        sw_wr;

  assign sw_wr     = ctr.wr_lo | ctr.wr_hi;
  assign ctr.count = count_reg;
  assign ctr.tick  = tick_reg;
  assign ctr.ovf   = ovf_reg;

  // ==========================================================
  // Shared time base
  // ==========================================================
  // A software write wins over the increment in the same cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= CAW_RST_CNT;
    end else if (sw_wr) begin  // see R10
      if (ctr.wr_lo) begin
        count_reg[7:0] <= ctr.wdata;
      end
      if (ctr.wr_hi) begin
        count_reg[15:8] <= ctr.wdata;
      end
    end else if (ctr.run) begin  // see R13
      count_reg <= 16'(count_reg + 16'h0001);
    end
  end

  // Tick lines up with the freshly advanced count value
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_reg <= 1'b0;
      ovf_reg  <= 1'b0;
    end else begin
      tick_reg <= ctr.run & ~sw_wr;
      ovf_reg  <= ctr.run & ~sw_wr & (count_reg == CAW_CNT_MAX);  // see R12
    end
  end

endmodule

// [caw_ctr_if.sv]
`timescale 1ns/10ps
interface caw_ctr_if;
  logic        run;
  logic        wr_lo;
  logic        wr_hi;
  logic [7:0]  wdata;
  logic [15:0] count;
  logic        tick;
  logic        ovf;

  modport ctrl (output run, output wr_lo, output wr_hi, output wdata,
                input count, input tick, input ovf);
  modport counter (input run, input wr_lo, input wr_hi, input wdata,
                   output count, output tick, output ovf);
endinterface

// [caw_pkg.sv]
package caw_pkg;

  // ==========================================================
  // Register map (byte addresses on the plain register port)
  // ==========================================================
  localparam int         CAW_AW           = 4;
  localparam logic [3:0] CAW_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] CAW_ADDR_MODE    = 4'h1;
  localparam logic [3:0] CAW_ADDR_CNT_LO  = 4'h2;
  localparam logic [3:0] CAW_ADDR_CNT_HI  = 4'h3;
  localparam logic [3:0] CAW_ADDR_M4_MODE = 4'h4;
  localparam logic [3:0] CAW_ADDR_CMP_LO  = 4'h5;
  localparam logic [3:0] CAW_ADDR_CMP_HI  = 4'h6;
  localparam logic [3:0] CAW_ADDR_IRQ_ST  = 4'h7;
  localparam logic [3:0] CAW_ADDR_IRQ_MSK = 4'h8;

  // ==========================================================
  // Field positions
  // ==========================================================
  // counter_array_control
  localparam int CAW_CTL_OVF  = 7;
  localparam int CAW_CTL_RUN  = 6;
  localparam int CAW_CTL_M4EV = 4;
  // counter_mode_register
  localparam int CAW_MODE_WATCHDOG_ENABLE_BIT = 6;
  localparam int CAW_MODE_OVIE = 0;
  // module 4 mode register
  localparam int CAW_M4_CMPEN = 6;
  localparam int CAW_M4_CAPP  = 5;
  localparam int CAW_M4_CAPN  = 4;
  localparam int CAW_M4_MATCH = 3;
  localparam int CAW_M4_TOG   = 2;
  localparam int CAW_M4_PWM   = 1;
  localparam int CAW_M4_EVIE  = 0;
  // irq status / mask
  localparam int CAW_IRQ_OVF  = 0;
  localparam int CAW_IRQ_M4   = 1;
  localparam int CAW_IRQ_WDOG = 2;
  localparam int CAW_NIRQ     = 3;

  // ==========================================================
  // Reset values and counts
  // ==========================================================
  localparam logic [7:0]  CAW_RST_BYTE    = 8'h00;
  localparam logic [15:0] CAW_RST_CNT     = 16'h0000;
  localparam logic [15:0] CAW_CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CAW_RST_CMP     = 16'hFFFF;
  localparam logic [2:0]  CAW_RST_IRQ     = 3'h0;
  localparam int          CAW_WDRST_NS    = 40;
  localparam int          CAW_CLK_MHZ     = 100;
  localparam logic [3:0]  CAW_WDRST_CYC   =
    4'((CAW_WDRST_NS * CAW_CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {
    CAW_WD_IDLE  = 2'b00,
    CAW_WD_ARMED = 2'b01,
    CAW_WD_FIRE  = 2'b10
  } caw_wd_state_t;

endpackage

// [caw_top.sv]
`timescale 1ns/10ps
// Operation
// R1: Only module 4 of the counter array can produce the watchdog reset.
// R2: With the watchdog off, module 4 keeps its ordinary compare behaviour.
// R3: The watchdog is active only with module 4 in a compare mode and enable set.
// R4: A 16-bit compare pair for module 4 is matched against the full counter.
// R5: A match while the watchdog is active issues an internal chip reset.
// R6: The internal reset never drives the external reset pin.
// R7: Software holds off the reset by moving the compare value periodically.
// R8: Software may instead rewrite the counter, which disturbs other modules.
// R9: Clearing the enable before a match suppresses the reset; setting re-arms.
// R10: One shared 16-bit counter is the time base of every module.
// R11: Software refreshes from the main program within 2^16 counts.
// R12: Rollover sets the overflow flag, which interrupts if enabled, SW clears.
// R13: The counter advances only while the run bit is set.
module caw_top
  import caw_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [CAW_AW-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  output logic                   irq_o,
  output logic                   wdog_reset_o,
  output logic                   reset_pin_oe_o,
  output logic                   m4_compare_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  caw_ctr_if ctr ();

  logic                 run_reg;
  logic                 ovf_flag_reg;
  logic                 m4_flag_reg;
  logic                 watchdog_enable_bit_reg;
  logic                 ovie_reg;
  logic [6:0]           m4_mode_reg;
  logic [15:0]          cmp_reg;
  logic [CAW_NIRQ-1:0]  irq_st_reg;
  logic [CAW_NIRQ-1:0]  irq_msk_reg;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic                 irq_reg;
  logic                 wdrst_reg;
  logic                 pin_oe_reg;
  logic                 m4_out_reg;
  logic [3:0]           wdrst_cnt_reg;
  caw_wd_state_t        wd_state_reg;
  caw_wd_state_t        wd_state_next;

  logic                 wr_ctl;
  logic                 wr_mode;
  logic                 wr_m4;
  logic                 wr_cmp_lo;
  logic                 wr_cmp_hi;
  logic                 wr_st;
  logic                 wr_msk;
  logic                 cmp_mode;
  logic                 wd_active;
  logic                 match_ev;
  logic                 wd_fire;
  logic [CAW_NIRQ-1:0]  irq_ev;

  // ==========================================================
  // Register decode
  // ==========================================================
  assign wr_ctl    = wr_i & (addr_i == CAW_ADDR_CONTROL);
  assign wr_mode   = wr_i & (addr_i == CAW_ADDR_MODE);
  assign wr_m4     = wr_i & (addr_i == CAW_ADDR_M4_MODE);
  assign wr_cmp_lo = wr_i & (addr_i == CAW_ADDR_CMP_LO);
  assign wr_cmp_hi = wr_i & (addr_i == CAW_ADDR_CMP_HI);
  assign wr_st     = wr_i & (addr_i == CAW_ADDR_IRQ_ST);
  assign wr_msk    = wr_i & (addr_i == CAW_ADDR_IRQ_MSK);

  assign ctr.run   = run_reg;
  assign ctr.wr_lo = wr_i & (addr_i == CAW_ADDR_CNT_LO);
  assign ctr.wr_hi = wr_i & (addr_i == CAW_ADDR_CNT_HI);
  assign ctr.wdata = wdata_i;

  caw_counter u_counter (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ctr     (ctr)
  );

  // ==========================================================
  // Control register
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_reg <= 1'b0;
    end else if (wr_ctl) begin
      run_reg <= wdata_i[CAW_CTL_RUN];  // see R13
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ovf_flag_reg <= 1'b0;
    end else if (ctr.ovf) begin
      ovf_flag_reg <= 1'b1;  // see R12
    end else if (wr_ctl) begin
      ovf_flag_reg <= wdata_i[CAW_CTL_OVF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      m4_flag_reg <= 1'b0;
    end else if (match_ev) begin
      m4_flag_reg <= 1'b1;
    end else if (wr_ctl) begin
      m4_flag_reg <= wdata_i[CAW_CTL_M4EV];
    end
  end

  // ==========================================================
  // Mode registers
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      watchdog_enable_bit_reg <= 1'b0;
      ovie_reg <= 1'b0;
    end else if (wr_mode) begin
      watchdog_enable_bit_reg <= wdata_i[CAW_MODE_WATCHDOG_ENABLE_BIT];  // see R9
      ovie_reg <= wdata_i[CAW_MODE_OVIE];
    end
  end

  // Writing the low compare byte drops compare enable and the high byte
  // restores it, so a value written low byte first cannot produce a false match while half-written.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      m4_mode_reg <= 7'h00;
    end else if (wr_m4) begin
      m4_mode_reg <= wdata_i[6:0];
    end else if (wr_cmp_lo) begin
      m4_mode_reg[CAW_M4_CMPEN] <= 1'b0;
    end else if (wr_cmp_hi) begin
      m4_mode_reg[CAW_M4_CMPEN] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmp_reg <= CAW_RST_CMP;
    end else begin
      if (wr_cmp_lo) begin
        cmp_reg[7:0] <= wdata_i;  // see R4
      end
      if (wr_cmp_hi) begin
        cmp_reg[15:8] <= wdata_i;  // see R4
      end
    end
  end

  // ==========================================================
  // Module 4 compare and watchdog
  // ==========================================================
  // Software-timer or toggle compare; capture and PWM settings are not
  // compare modes and therefore never arm the watchdog.
  assign cmp_mode = m4_mode_reg[CAW_M4_CMPEN] & m4_mode_reg[CAW_M4_MATCH] &
                    ~m4_mode_reg[CAW_M4_PWM] & ~m4_mode_reg[CAW_M4_CAPP] &
                    ~m4_mode_reg[CAW_M4_CAPN];  // see R3
  assign wd_active = cmp_mode & watchdog_enable_bit_reg;  // see R3
  // Compared only on counter advance: one event per pass over the value
  assign match_ev  = cmp_mode & ctr.tick & (ctr.count == cmp_reg);  // see R4
  assign wd_fire   = wd_active & match_ev;  // see R1

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      m4_out_reg <= 1'b0;
    end else if (match_ev & m4_mode_reg[CAW_M4_TOG]) begin
      m4_out_reg <= ~m4_out_reg;  // see R2
    end
  end

  always_comb begin
    wd_state_next = wd_state_reg;
    case (wd_state_reg)
      CAW_WD_IDLE: begin
        if (wd_active) begin
          wd_state_next = CAW_WD_ARMED;
        end
      end
      CAW_WD_ARMED: begin
        if (wd_fire) begin
          wd_state_next = CAW_WD_FIRE;  // see R5
        end else if (!wd_active) begin
          wd_state_next = CAW_WD_IDLE;  // see R9
        end
      end
      CAW_WD_FIRE: begin
        if (wdrst_cnt_reg == 4'h1) begin
          wd_state_next = CAW_WD_IDLE;
        end
      end
      default: begin
        wd_state_next = CAW_WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wd_state_reg <= CAW_WD_IDLE;
    end else begin
      wd_state_reg <= wd_state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdrst_cnt_reg <= 4'h0;
      wdrst_reg     <= 1'b0;
    end else if (wd_state_reg == CAW_WD_ARMED && wd_fire) begin
      wdrst_cnt_reg <= CAW_WDRST_CYC;
      wdrst_reg     <= 1'b1;  // see R5
    end else if (wdrst_cnt_reg != 4'h0) begin
      wdrst_cnt_reg <= 4'(wdrst_cnt_reg - 4'h1);
      wdrst_reg     <= (wdrst_cnt_reg != 4'h1);
    end else begin
      wdrst_reg     <= 1'b0;
    end
  end

  // The pin driver stays off: the watchdog reset is internal only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= 1'b0;  // see R6
    end
  end

  // ==========================================================
  // Interrupt status and mask
  // ==========================================================
  assign irq_ev[CAW_IRQ_OVF]  = ctr.ovf;
  assign irq_ev[CAW_IRQ_M4]   = match_ev;
  assign irq_ev[CAW_IRQ_WDOG] = wd_fire & (wd_state_reg == CAW_WD_ARMED);

  genvar gi;
  generate
    for (gi = 0; gi < CAW_NIRQ; gi++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          irq_st_reg[gi] <= 1'b0;
        end else if (irq_ev[gi]) begin
          irq_st_reg[gi] <= 1'b1;
        end else if (wr_st && wdata_i[gi]) begin
          irq_st_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_msk_reg <= CAW_RST_IRQ;
    end else if (wr_msk) begin
      irq_msk_reg <= wdata_i[CAW_NIRQ-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (|(irq_st_reg & irq_msk_reg)) |
                 (ovf_flag_reg & ovie_reg) |  // see R12
                 (m4_flag_reg & m4_mode_reg[CAW_M4_EVIE]);
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always_comb begin
    rdata_next = CAW_RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        CAW_ADDR_CONTROL: begin
          rdata_next[CAW_CTL_OVF]  = ovf_flag_reg;
          rdata_next[CAW_CTL_RUN]  = run_reg;
          rdata_next[CAW_CTL_M4EV] = m4_flag_reg;
        end
        CAW_ADDR_MODE: begin
          rdata_next[CAW_MODE_WATCHDOG_ENABLE_BIT] = watchdog_enable_bit_reg;
          rdata_next[CAW_MODE_OVIE] = ovie_reg;
        end
        CAW_ADDR_CNT_LO: begin
          rdata_next = ctr.count[7:0];
        end
        CAW_ADDR_CNT_HI: begin
          rdata_next = ctr.count[15:8];
        end
        CAW_ADDR_M4_MODE: begin
          rdata_next = {1'b0, m4_mode_reg};
        end
        CAW_ADDR_CMP_LO: begin
          rdata_next = cmp_reg[7:0];
        end
        CAW_ADDR_CMP_HI: begin
          rdata_next = cmp_reg[15:8];
        end
        CAW_ADDR_IRQ_ST: begin
          rdata_next[CAW_NIRQ-1:0] = irq_st_reg;
        end
        CAW_ADDR_IRQ_MSK: begin
          rdata_next[CAW_NIRQ-1:0] = irq_msk_reg;
        end
        default: begin
          rdata_next = CAW_RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= CAW_RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o        = rdata_reg;
  assign irq_o          = irq_reg;
  assign wdog_reset_o   = wdrst_reg;
  assign reset_pin_oe_o = pin_oe_reg;
  assign m4_compare_o   = m4_out_reg;

endmodule

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top
  import caw_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [CAW_AW-1:0] addr_i = '0;
  logic [7:0]        wdata_i = 8'h00;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic [7:0]        rdata_o;
  logic              irq_o;
  logic              wdog_reset_o;
  logic              reset_pin_oe_o;
  logic              m4_compare_o;
  logic [7:0]        d;
  logic [7:0]        pins;
  logic              wd_q = 1'b0;
  logic              tg_q = 1'b0;
  int                bad_count = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                pulses = 0;
  int                toggles = 0;
  logic [7:0]        rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  always #5 clk_i = ~clk_i;

  caw_top dut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .wdog_reset_o(wdog_reset_o), .reset_pin_oe_o(reset_pin_oe_o),
    .m4_compare_o(m4_compare_o)
  );

  // ==========
  // Event counters and hang limit
  // ==========
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    wd_q <= wdog_reset_o;
    tg_q <= m4_compare_o;
    if (wdog_reset_o === 1'b1 && wd_q !== 1'b1) pulses <= pulses + 1;
    if (!reset_i && m4_compare_o !== tg_q) toggles <= toggles + 1;
    if (cycles == 8000) begin
      bad_count = bad_count + 1;
      results();
    end
  end

  // ==========
  // Access tasks
  // ==========
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A write is followed by one idle cycle so no strobe is set twice
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask

  // Single-bit outputs are read just after the edge that launches them,
  // then the bench falls back onto the next edge for its next request
  task automatic look();
    #1 pins = {4'h0, m4_compare_o, reset_pin_oe_o, wdog_reset_o, irq_o};
    @(posedge clk_i);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  // ==========
  initial begin
    int k;
    int p0;
    int t0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    wr(4'h9, 8'h5A);
    for (int i = 0; i < 10; i++) begin
      rd(4'(i));
      chk(d, rst_tab[i]);
    end
    // Counter stopped, then run for a known span
    wr(CAW_ADDR_CNT_LO, 8'h10);
    rd(CAW_ADDR_CNT_LO);
    chk(d, 8'h10);
    wr(CAW_ADDR_CONTROL, 8'h40);
    repeat (20) @(posedge clk_i);
    wr(CAW_ADDR_CONTROL, 8'h00);
    rd(CAW_ADDR_CNT_LO);
    chk(d, 8'h26);
    rd(CAW_ADDR_CNT_LO);
    chk(d, 8'h26);
    // Rollover flag, interrupt, mask and clear
    wr(CAW_ADDR_CNT_LO, 8'hFF);
    wr(CAW_ADDR_CNT_HI, 8'hFF);
    wr(CAW_ADDR_MODE, 8'h01);
    wr(CAW_ADDR_CONTROL, 8'h40);
    wr(CAW_ADDR_CONTROL, 8'h80);
    rd(CAW_ADDR_CONTROL);
    chk(d, 8'h80);
    look();
    chk({7'h0, pins[0]}, 8'h01);
    rd(CAW_ADDR_CNT_LO);
    chk(d, 8'h01);
    wr(CAW_ADDR_CONTROL, 8'h00);
    wr(CAW_ADDR_MODE, 8'h00);
    look();
    chk({7'h0, pins[0]}, 8'h00);
    wr(CAW_ADDR_IRQ_MSK, 8'h01);
    look();
    chk({7'h0, pins[0]}, 8'h01);
    wr(CAW_ADDR_IRQ_ST, 8'h01);
    look();
    chk({7'h0, pins[0]}, 8'h00);
    // Watchdog match on the full 16-bit value only
    p0 = pulses;
    wr(CAW_ADDR_CNT_LO, 8'h00);
    wr(CAW_ADDR_M4_MODE, 8'h48);
    wr(CAW_ADDR_CMP_LO, 8'h20);
    wr(CAW_ADDR_CMP_HI, 8'h01);
    wr(CAW_ADDR_IRQ_MSK, 8'h04);
    wr(CAW_ADDR_MODE, 8'h40);
    wr(CAW_ADDR_CONTROL, 8'h40);
    repeat (250) @(posedge clk_i);
    chk(8'(pulses - p0), 8'h00);
    for (k = 0; k < 100 && wdog_reset_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    chk({7'h0, wdog_reset_o}, 8'h01);
    chk({7'h0, reset_pin_oe_o}, 8'h00);
    @(posedge clk_i);
    look();
    chk({7'h0, pins[0]}, 8'h01);
    rd(CAW_ADDR_IRQ_ST);
    chk(d & 8'h04, 8'h04);
    rd(CAW_ADDR_CONTROL);
    chk(d, 8'h50);
    // Hold-off by moving the compare value
    wr(CAW_ADDR_IRQ_ST, 8'h07);
    wr(CAW_ADDR_CONTROL, 8'h40);
    p0 = pulses;
    wr(CAW_ADDR_CNT_HI, 8'h00);
    wr(CAW_ADDR_CNT_LO, 8'h00);
    for (int i = 1; i < 5; i++) begin
      wr(CAW_ADDR_CMP_LO, 8'h00);
      wr(CAW_ADDR_CMP_HI, 8'(2 * i));
      repeat (300) @(posedge clk_i);
    end
    chk(8'(pulses - p0), 8'h00);
    // Hold-off by rewriting the shared counter
    wr(CAW_ADDR_CNT_HI, 8'h00);
    wr(CAW_ADDR_CNT_LO, 8'h00);
    wr(CAW_ADDR_CMP_LO, 8'h00);
    wr(CAW_ADDR_CMP_HI, 8'h01);
    for (int i = 0; i < 4; i++) begin
      repeat (200) @(posedge clk_i);
      wr(CAW_ADDR_CNT_HI, 8'h00);
      wr(CAW_ADDR_CNT_LO, 8'h00);
    end
    chk(8'(pulses - p0), 8'h00);
    // Enable cleared: module 4 still compares, no reset
    wr(CAW_ADDR_MODE, 8'h00);
    wr(CAW_ADDR_M4_MODE, 8'h4C);
    wr(CAW_ADDR_CMP_HI, 8'h01);
    t0 = toggles;
    repeat (300) @(posedge clk_i);
    chk(8'(pulses - p0), 8'h00);
    chk(8'(toggles - t0), 8'h01);
    rd(CAW_ADDR_CONTROL);
    chk(d, 8'h50);
    // Enable set again re-arms the watchdog
    wr(CAW_ADDR_MODE, 8'h40);
    wr(CAW_ADDR_CNT_HI, 8'h00);
    wr(CAW_ADDR_CNT_LO, 8'h00);
    repeat (300) @(posedge clk_i);
    chk(8'(pulses - p0), 8'h01);
    // A PWM setting is not a compare mode, so the watchdog stays quiet
    wr(CAW_ADDR_M4_MODE, 8'h4A);
    wr(CAW_ADDR_CNT_HI, 8'h00);
    wr(CAW_ADDR_CNT_LO, 8'h00);
    repeat (300) @(posedge clk_i);
    chk(8'(pulses - p0), 8'h01);
    results();
  end
endmodule
